/* src/scag_consts.svh */
`ifndef SCAG_CONSTS_SVH
`define SCAG_CONSTS_SVH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define SCAG_A_CTRL 12'h000
`define SCAG_A_FUSE 12'h004
`define SCAG_A_BLOW 12'h008
`define SCAG_A_PWDAT 12'h00c
`define SCAG_A_PWCMD 12'h010
`define SCAG_A_STAT 12'h014
`define SCAG_A_ZKEY 12'h020
`define SCAG_A_PCNT 12'h040
`define SCAG_A_ACNT 12'h080
`define SCAG_A_MADR 12'h100
`define SCAG_A_MDAT 12'h104
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SCAG_OPT_EIGHT 0
`define SCAG_OPT_UNLIM 1
`define SCAG_F_FAB 2'h0
`define SCAG_F_CMA 2'h1
`define SCAG_F_PER 2'h2
`define SCAG_F_LOT 2'h3
// ----------------------------------------
// Reset and counter values
// ----------------------------------------
`define SCAG_CNT_FULL 8'hff
`define SCAG_CNT_LOCK 8'h00
`define SCAG_ZKEY_RST 8'hff
// ----------------------------------------
// Secure memory word map
// ----------------------------------------
`define SCAG_W_ID_END 6'h01
`define SCAG_W_TEST 6'h02
`define SCAG_W_MAKER 6'h03
`define SCAG_W_LOT 6'h04
`define SCAG_G_CRYPT 3'h1
`define SCAG_G_SKEY 3'h2
`define SCAG_G_SEED 3'h3
`define SCAG_G_PW 2'h2
// ----------------------------------------
// Bus answers
// ----------------------------------------
`define SCAG_RESP_OKAY 2'h0
`define SCAG_RESP_SLVERR 2'h2
`endif

/* src/scag_pkg.sv */
package scag_pkg;
	typedef enum logic [2:0] {
		SCAG_IDLE = 3'b000,
		SCAG_RD = 3'b001,
		SCAG_PW = 3'b010,
		SCAG_C0 = 3'b011,
		SCAG_C1 = 3'b100,
		SCAG_S0 = 3'b101,
		SCAG_S1 = 3'b110
	} scag_state_t;
	typedef struct packed {
		logic [1:0] key_set;
		logic enc;
		logic pass;
		logic [55:0] crypt_new;
		logic [63:0] skey_new;
	} scag_auth_t;
	typedef struct packed {
		logic [1:0] key_set;
		logic [1:0] field;
		logic half;
	} scag_cip_sel_t;
endpackage : scag_pkg

/* src/scag_mem.sv */
`timescale 1ns/10ps
`default_nettype none
module scag_mem
(
	// Clock
	input wire logic aclk,
	// Write port
	input wire logic we,
	input wire logic [5:0] waddr,
	input wire logic [31:0] wdata,
	// Registered read ports
	input wire logic [5:0] ra_addr,
	output logic [31:0] ra_data,
	input wire logic [5:0] rb_addr,
	output logic [31:0] rb_data
);
	// ----------------------------------------
	// Storage, no reset: blank at power-up, then persists
	// ----------------------------------------
	logic [31:0] mem_r [64] = '{default: 32'h0000_0000};

	always_ff @(posedge aclk)
	begin
		if (we)
		begin
			mem_r[waddr] <= wdata;
		end
	end

	always_ff @(posedge aclk)
	begin
		ra_data <= mem_r[ra_addr];
		rb_data <= mem_r[rb_addr];
	end
endmodule : scag_mem
`default_nettype wire

/* src/scag_top.sv */
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "scag_consts.svh"
// Contract
// - Zone key bits [2:0] pick the zone's password set.
// - Four 56-bit cryptograms; one rewritten per passed authentication.
// - Four 64-bit session keys, rewritten on passed authentication or encryption.
// - Four 64-bit seeds served with matching cryptogram and session key.
// - Eight sets of 24-bit read and write passwords.
// - Verified write password lets host rewrite its set's passwords.
// - Write password 7 is the secure code granting configuration writes.
// - Secure code changes only after it was verified.
// - Blown personalization fuse: secure code grants no configuration writes.
// - Sixteen 8-bit password try counters, one per password.
// - Wrong password steps counter FF, EE, CC, 88, 00; 00 locks until reset or a counter write.
// - Correct password with nonzero counter restores FF.
// - Four auth try counters step FF, EE, CC, 88, 00; 00 locks.
// - Passed authentication with nonzero counter restores FF.
// - Fuse status bits 0 to 3, zero means blown; rest reserved.
// - A blown fuse never returns unblown, by command or reset.
// - Fuses blow fabrication, maker, personalization in order; out-of-order blows rejected, lot fuse blows any time.
// - Fabrication, maker and personalization fuses each lock their configuration area as they blow; the lot fuse locks nothing.
// - Identification, test, maker and lot regions follow their fuse write rules.
// - Secret regions need secure code until personalization, then forbidden.
// - Eight-trial option steps counters FF, FE, FC, ... 80, 00.
// - Unlimited option still decrements, never locks key sets.
module scag_top
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Nonvolatile fuse cells
	input wire logic [3:0] fuse_nv_in,
	output logic fuse_burn,
	output logic [1:0] fuse_burn_id,
	// Cipher engine results
	input wire logic auth_valid,
	input wire scag_pkg::scag_auth_t auth_req,
	output logic auth_ready,
	output logic [3:0] auth_locked,
	// Cipher engine key fetch
	input wire scag_pkg::scag_cip_sel_t cip_sel,
	output logic [31:0] cip_word,
	// Zone grants
	output logic [7:0] zone_read_grant,
	output logic [7:0] zone_write_grant
);
	import scag_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [1:0] opt_r;
	logic [3:0] fuse_r;
	logic [23:0] pw_data_r;
	logic [5:0] mem_addr_r;
	logic [7:0] zkey_r [8];
	logic [7:0] pcnt_r [16];
	logic [7:0] acnt_r [4];
	logic [7:0] pw_rd_ok_r;
	logic [7:0] pw_wr_ok_r;
	logic pw_pass_r;
	logic pw_lock_r;
	scag_state_t state_r;
	logic [3:0] pw_idx_r;
	scag_auth_t au_r;
	logic aw_have_r;
	logic w_have_r;
	logic ar_have_r;
	logic [11:0] aw_addr_r;
	logic [11:0] ar_addr_r;
	logic [31:0] w_data_r;
	logic w_full_r;
	logic bvalid_r;
	logic rvalid_r;
	logic [1:0] bresp_r;
	logic [1:0] rresp_r;
	logic [31:0] rdata_r;
	logic fuse_burn_r;
	logic [1:0] fuse_burn_id_r;
	logic [3:0] auth_locked_r;
	logic [7:0] zr_r;
	logic [7:0] zw_r;
	logic [7:0] zr_nxt;
	logic [7:0] zw_nxt;

	logic secure_ok;
	logic mem_rd_ok;
	logic mem_wr_ok;
	logic auth_go;
	logic au_lock;
	logic wr_go;
	logic rd_go;
	logic w_err;
	logic w_ctrl;
	logic w_blow;
	logic w_pwdat;
	logic w_pwcmd;
	logic w_zkey;
	logic w_pcnt;
	logic w_acnt;
	logic w_madr;
	logic w_mdat;
	logic [31:0] rd_val;
	logic rd_err;
	logic rd_mem;
	logic [5:0] pa_addr;
	logic [31:0] pa_data;
	logic [5:0] pb_addr;
	logic mw_en;
	logic [5:0] mw_addr;
	logic [31:0] mw_data;
	logic [1:0] cip_field;
	logic pw_hit;
	logic [7:0] pc_cur;

	// Counter step; eight-trial shifts the whole byte, else each nibble
	function automatic logic [7:0] scag_step(input logic [7:0] v, input logic eight);
		scag_step = eight ? {v[6:0], 1'b0} : {v[6:4], 1'b0, v[2:0], 1'b0};
	endfunction : scag_step

	// ----------------------------------------
	// Secure memory
	// ----------------------------------------
	scag_mem u_mem
	(
		.aclk(aclk),
		.we(mw_en),
		.waddr(mw_addr),
		.wdata(mw_data),
		.ra_addr(pa_addr),
		.ra_data(pa_data),
		.rb_addr(pb_addr),
		.rb_data(cip_word)
	);

	// Key set words to the cipher
	assign cip_field = (cip_sel.field == 2'h3) ? 2'h2 : cip_sel.field;
	assign pb_addr = {3'({1'b0, cip_field}) + 3'h1, cip_sel.key_set, cip_sel.half};

	// ----------------------------------------
	// Access rights
	// ----------------------------------------
	assign secure_ok = pw_wr_ok_r[7] & fuse_r[`SCAG_F_PER];

	always_comb
	begin
		mem_rd_ok = 1'b0;
		mem_wr_ok = 1'b0;
		if (mem_addr_r <= `SCAG_W_ID_END)
		begin
			mem_rd_ok = 1'b1;
			mem_wr_ok = secure_ok & fuse_r[`SCAG_F_FAB];
		end
		else if (mem_addr_r == `SCAG_W_TEST)
		begin
			mem_rd_ok = 1'b1;
			mem_wr_ok = 1'b1;
		end
		else if (mem_addr_r == `SCAG_W_MAKER)
		begin
			mem_rd_ok = 1'b1;
			mem_wr_ok = secure_ok & fuse_r[`SCAG_F_CMA];
		end
		else if (mem_addr_r == `SCAG_W_LOT)
		begin
			mem_rd_ok = 1'b1;
		end
		else if (mem_addr_r[5:3] == `SCAG_G_CRYPT)
		begin
			mem_rd_ok = 1'b1;
			mem_wr_ok = secure_ok;
		end
		else if (mem_addr_r[5:3] == `SCAG_G_SKEY || mem_addr_r[5:3] == `SCAG_G_SEED)
		begin
			mem_rd_ok = secure_ok;
			mem_wr_ok = secure_ok;
		end
		else if (mem_addr_r[5:4] == `SCAG_G_PW)
		begin
			// Secure code word needs set 7 verified either way
			mem_rd_ok = pw_wr_ok_r[mem_addr_r[3:1]] | secure_ok;
			mem_wr_ok = pw_wr_ok_r[mem_addr_r[3:1]] | secure_ok;
		end
	end

	// ----------------------------------------
	// Bus handshake
	// ----------------------------------------
	assign s_axi_awready = !aw_have_r;
	assign s_axi_wready = !w_have_r;
	assign s_axi_arready = !ar_have_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;
	assign auth_ready = (state_r == SCAG_IDLE);
	assign auth_go = auth_valid & (state_r == SCAG_IDLE);
	assign au_lock = (acnt_r[auth_req.key_set] == `SCAG_CNT_LOCK) & !opt_r[`SCAG_OPT_UNLIM];
	assign wr_go = aw_have_r & w_have_r & !bvalid_r & (state_r == SCAG_IDLE) & !auth_go;
	assign rd_go = ar_have_r & !rvalid_r & (state_r == SCAG_IDLE) & !auth_go & !wr_go;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			aw_addr_r <= 12'h000;
			w_data_r <= 32'h0000_0000;
			w_full_r <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid && !aw_have_r)
			begin
				aw_have_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			else if (wr_go)
			begin
				aw_have_r <= 1'b0;
			end
			if (s_axi_wvalid && !w_have_r)
			begin
				w_have_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_full_r <= (s_axi_wstrb == 4'hf);
			end
			else if (wr_go)
			begin
				w_have_r <= 1'b0;
			end
		end
	end

	// Partial-strobe writes are refused: registers hold packed secrets
	always_comb
	begin
		w_err = 1'b0;
		w_ctrl = 1'b0;
		w_blow = 1'b0;
		w_pwdat = 1'b0;
		w_pwcmd = 1'b0;
		w_zkey = 1'b0;
		w_pcnt = 1'b0;
		w_acnt = 1'b0;
		w_madr = 1'b0;
		w_mdat = 1'b0;
		if (!w_full_r)
			w_err = 1'b1;
		else if (aw_addr_r == `SCAG_A_CTRL)
			w_ctrl = 1'b1;
		else if (aw_addr_r == `SCAG_A_BLOW)
		begin
			// Out-of-order blow answers with an error
			if (w_data_r[1:0] == `SCAG_F_CMA)
				w_blow = !fuse_r[`SCAG_F_FAB];
			else if (w_data_r[1:0] == `SCAG_F_PER)
				w_blow = !fuse_r[`SCAG_F_CMA];
			else
				w_blow = 1'b1;
			w_err = !w_blow;
		end
		else if (aw_addr_r == `SCAG_A_PWDAT)
			w_pwdat = 1'b1;
		else if (aw_addr_r == `SCAG_A_PWCMD)
			w_pwcmd = 1'b1;
		else if (aw_addr_r == `SCAG_A_MADR)
			w_madr = 1'b1;
		else if (aw_addr_r == `SCAG_A_MDAT)
		begin
			w_mdat = mem_wr_ok;
			w_err = !mem_wr_ok;
		end
		else if (aw_addr_r[11:5] == `SCAG_A_ZKEY >> 5)
		begin
			w_zkey = secure_ok;
			w_err = !secure_ok;
		end
		else if (aw_addr_r[11:6] == `SCAG_A_PCNT >> 6)
		begin
			w_pcnt = secure_ok | (!fuse_r[`SCAG_F_PER] & pw_wr_ok_r[aw_addr_r[5:3]]);
			w_err = !w_pcnt;
		end
		else if (aw_addr_r[11:4] == `SCAG_A_ACNT >> 4)
		begin
			w_acnt = secure_ok;
			w_err = !secure_ok;
		end
		else
			w_err = 1'b1;
	end

	always_comb
	begin
		rd_val = 32'h0000_0000;
		rd_err = 1'b0;
		rd_mem = 1'b0;
		if (ar_addr_r == `SCAG_A_CTRL)
			rd_val = {30'h0000_0000, opt_r};
		else if (ar_addr_r == `SCAG_A_FUSE)
			rd_val = {28'h000_0000, fuse_r};
		else if (ar_addr_r == `SCAG_A_STAT)
			rd_val = {8'h00, pw_wr_ok_r, pw_rd_ok_r, 5'h00, pw_lock_r, pw_pass_r, secure_ok};
		else if (ar_addr_r == `SCAG_A_MADR)
			rd_val = {26'h000_0000, mem_addr_r};
		else if (ar_addr_r == `SCAG_A_MDAT)
		begin
			rd_mem = mem_rd_ok;
			rd_err = !mem_rd_ok;
		end
		else if (ar_addr_r[11:5] == `SCAG_A_ZKEY >> 5)
			rd_val = {24'h00_0000, zkey_r[ar_addr_r[4:2]]};
		else if (ar_addr_r[11:6] == `SCAG_A_PCNT >> 6)
			rd_val = {24'h00_0000, pcnt_r[ar_addr_r[5:2]]};
		else if (ar_addr_r[11:4] == `SCAG_A_ACNT >> 4)
			rd_val = {24'h00_0000, acnt_r[ar_addr_r[3:2]]};
		else
			rd_err = 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_r <= 1'b0;
			bresp_r <= `SCAG_RESP_OKAY;
		end
		else if (wr_go)
		begin
			bvalid_r <= 1'b1;
			bresp_r <= w_err ? `SCAG_RESP_SLVERR : `SCAG_RESP_OKAY;
		end
		else if (s_axi_bready)
		begin
			bvalid_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ar_have_r <= 1'b0;
			ar_addr_r <= 12'h000;
			rvalid_r <= 1'b0;
			rresp_r <= `SCAG_RESP_OKAY;
			rdata_r <= 32'h0000_0000;
		end
		else
		begin
			if (s_axi_arvalid && !ar_have_r)
			begin
				ar_have_r <= 1'b1;
				ar_addr_r <= s_axi_araddr;
			end
			else if ((rd_go && !rd_mem) || state_r == SCAG_RD)
			begin
				ar_have_r <= 1'b0;
			end
			if (rd_go && !rd_mem)
			begin
				rvalid_r <= 1'b1;
				rdata_r <= rd_val;
				rresp_r <= rd_err ? `SCAG_RESP_SLVERR : `SCAG_RESP_OKAY;
			end
			else if (state_r == SCAG_RD)
			begin
				rvalid_r <= 1'b1;
				rdata_r <= pa_data;
				rresp_r <= `SCAG_RESP_OKAY;
			end
			else if (s_axi_rready)
			begin
				rvalid_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Sequencer and memory port steering
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_r <= SCAG_IDLE;
			pw_idx_r <= 4'h0;
			au_r <= '0;
		end
		else
		begin
			case (state_r)
				SCAG_IDLE:
				begin
					if (auth_go)
					begin
						au_r <= auth_req;
						if (auth_req.pass && !au_lock)
							state_r <= auth_req.enc ? SCAG_S0 : SCAG_C0;
					end
					else if (wr_go && w_pwcmd)
					begin
						pw_idx_r <= w_data_r[3:0];
						state_r <= SCAG_PW;
					end
					else if (rd_go && rd_mem)
						state_r <= SCAG_RD;
				end
				SCAG_C0: state_r <= SCAG_C1;
				SCAG_C1: state_r <= SCAG_S0;
				SCAG_S0: state_r <= SCAG_S1;
				default: state_r <= SCAG_IDLE;
			endcase
		end
	end

	assign pa_addr = (wr_go && w_pwcmd) ? {`SCAG_G_PW, w_data_r[3:0]} : mem_addr_r;

	always_comb
	begin
		mw_en = 1'b1;
		mw_addr = {`SCAG_G_SKEY, au_r.key_set, state_r == SCAG_S1};
		mw_data = (state_r == SCAG_S1) ? au_r.skey_new[63:32] : au_r.skey_new[31:0];
		case (state_r)
			SCAG_C0:
			begin
				mw_addr = {`SCAG_G_CRYPT, au_r.key_set, 1'b0};
				mw_data = au_r.crypt_new[31:0];
			end
			SCAG_C1:
			begin
				mw_addr = {`SCAG_G_CRYPT, au_r.key_set, 1'b1};
				mw_data = {8'h00, au_r.crypt_new[55:32]};
			end
			SCAG_S0, SCAG_S1: mw_en = 1'b1;
			default:
			begin
				mw_en = wr_go & w_mdat;
				mw_addr = mem_addr_r;
				mw_data = w_data_r;
			end
		endcase
	end

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			opt_r <= 2'h0;
			pw_data_r <= 24'h00_0000;
			mem_addr_r <= 6'h00;
		end
		else if (wr_go)
		begin
			if (w_ctrl)
				opt_r <= w_data_r[1:0];
			if (w_pwdat)
				pw_data_r <= w_data_r[23:0];
			if (w_madr)
				mem_addr_r <= w_data_r[5:0];
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < 8; i++)
				zkey_r[i] <= `SCAG_ZKEY_RST;
		end
		else if (wr_go && w_zkey)
		begin
			zkey_r[aw_addr_r[4:2]] <= w_data_r[7:0];
		end
	end

	// Fuse cells are reloaded at reset, so only a burn can change them
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			fuse_r <= fuse_nv_in;
			fuse_burn_r <= 1'b0;
			fuse_burn_id_r <= 2'h0;
		end
		else
		begin
			fuse_burn_r <= wr_go & w_blow;
			if (wr_go && w_blow)
			begin
				fuse_r[w_data_r[1:0]] <= 1'b0;
				fuse_burn_id_r <= w_data_r[1:0];
			end
		end
	end
	assign fuse_burn = fuse_burn_r;
	assign fuse_burn_id = fuse_burn_id_r;

	// ----------------------------------------
	// Password verification
	// ----------------------------------------
	assign pc_cur = pcnt_r[pw_idx_r];
	assign pw_hit = (pa_data[23:0] == pw_data_r);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < 16; i++)
				pcnt_r[i] <= `SCAG_CNT_FULL;
		end
		else if (state_r == SCAG_PW && pc_cur != `SCAG_CNT_LOCK)
		begin
			pcnt_r[pw_idx_r] <= pw_hit ? `SCAG_CNT_FULL : scag_step(pc_cur, opt_r[`SCAG_OPT_EIGHT]);
		end
		else if (wr_go && w_pcnt)
		begin
			pcnt_r[aw_addr_r[5:2]] <= w_data_r[7:0];
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pw_rd_ok_r <= 8'h00;
			pw_wr_ok_r <= 8'h00;
			pw_pass_r <= 1'b0;
			pw_lock_r <= 1'b0;
		end
		else if (state_r == SCAG_PW)
		begin
			// A locked password never verifies
			pw_pass_r <= pw_hit & (pc_cur != `SCAG_CNT_LOCK);
			pw_lock_r <= (pc_cur == `SCAG_CNT_LOCK);
			if (pw_idx_r[0])
				pw_wr_ok_r[pw_idx_r[3:1]] <= pw_hit & (pc_cur != `SCAG_CNT_LOCK);
			else
				pw_rd_ok_r[pw_idx_r[3:1]] <= pw_hit & (pc_cur != `SCAG_CNT_LOCK);
		end
	end

	// ----------------------------------------
	// Authentication counters
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < 4; i++)
				acnt_r[i] <= `SCAG_CNT_FULL;
		end
		else if (auth_go && !au_lock)
		begin
			if (!auth_req.pass)
				acnt_r[auth_req.key_set] <= scag_step(acnt_r[auth_req.key_set], opt_r[`SCAG_OPT_EIGHT]);
			else if (acnt_r[auth_req.key_set] != `SCAG_CNT_LOCK)
				acnt_r[auth_req.key_set] <= `SCAG_CNT_FULL;
		end
		else if (wr_go && w_acnt)
		begin
			acnt_r[aw_addr_r[3:2]] <= w_data_r[7:0];
		end
	end

	// ----------------------------------------
	// Grant outputs
	// ----------------------------------------
	for (genvar z = 0; z < 8; z++)
	begin : g_zone
		assign zw_nxt[z] = pw_wr_ok_r[zkey_r[z][2:0]];
		assign zr_nxt[z] = pw_rd_ok_r[zkey_r[z][2:0]] | pw_wr_ok_r[zkey_r[z][2:0]];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			zr_r <= 8'h00;
			zw_r <= 8'h00;
			auth_locked_r <= 4'h0;
		end
		else
		begin
			zr_r <= zr_nxt;
			zw_r <= zw_nxt;
			for (int k = 0; k < 4; k++)
				auth_locked_r[k] <= (acnt_r[k] == `SCAG_CNT_LOCK) & !opt_r[`SCAG_OPT_UNLIM];
		end
	end
	assign zone_read_grant = zr_r;
	assign zone_write_grant = zw_r;
	assign auth_locked = auth_locked_r;
endmodule : scag_top
`default_nettype wire

/* sim/scag_engine_model.sv */
`timescale 1ns/10ps
`default_nettype none
module scag_engine_model
(
	// Clock
	input wire logic aclk,
	// Fuse cells
	input wire logic fuse_burn,
	input wire logic [1:0] fuse_burn_id,
	output logic [3:0] fuse_nv_in,
	// Result source
	input wire logic go,
	input wire scag_pkg::scag_auth_t req,
	input wire logic auth_ready,
	output logic auth_valid,
	output scag_pkg::scag_auth_t auth_req
);
	import scag_pkg::*;
	// ----------------------------------------
	// Cells and cipher results
	// ----------------------------------------
	initial fuse_nv_in = 4'h7;
	initial auth_valid = 1'b0;
	initial auth_req = '0;
	always @(posedge aclk)
		if (fuse_burn)
			fuse_nv_in[fuse_burn_id] <= 1'b0;
	always @(posedge aclk)
		if (go && !auth_valid)
		begin
			auth_valid <= 1'b1;
			auth_req <= req;
		end
		else if (auth_valid && auth_ready)
		begin
			auth_valid <= 1'b0;
			auth_req <= ~auth_req;
		end
endmodule : scag_engine_model
`default_nettype wire

/* sim/scag_top_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
`include "scag_consts.svh"
module scag_top_monitor
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bus answers
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Fuses
	input wire logic [3:0] fuse_nv_in,
	input wire logic fuse_burn,
	input wire logic [1:0] fuse_burn_id,
	// Cipher results
	input wire logic auth_valid,
	input wire scag_pkg::scag_auth_t auth_req,
	input wire logic auth_ready,
	input wire logic [3:0] auth_locked
);
	import scag_pkg::*;
	logic [3:0] intact_r;
	logic take;
	default clocking mon_cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	assign take = auth_valid && auth_ready && !auth_locked[auth_req.key_set];
	always_ff @(posedge aclk)
		if (!aresetn)
			intact_r <= fuse_nv_in;
		else if (fuse_burn)
			intact_r[fuse_burn_id] <= 1'b0;
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
	property p_burn_pulse;
		fuse_burn |=> !fuse_burn;
	endproperty
	a_burn_pulse: assert property (p_burn_pulse) else $error("burn too long");
	property p_cma_order;
		fuse_burn && fuse_burn_id == `SCAG_F_CMA |-> !intact_r[`SCAG_F_FAB];
	endproperty
	a_cma_order: assert property (p_cma_order) else $error("maker fuse early");
	property p_per_order;
		fuse_burn && fuse_burn_id == `SCAG_F_PER |-> !intact_r[`SCAG_F_CMA];
	endproperty
	a_per_order: assert property (p_per_order) else $error("per fuse early");
	property p_auth_busy;
		take && auth_req.pass && !auth_req.enc |=> !auth_ready [*4];
	endproperty
	a_auth_busy: assert property (p_auth_busy) else $error("auth short");
	property p_enc_busy;
		take && auth_req.pass && auth_req.enc |=> !auth_ready [*2];
	endproperty
	a_enc_busy: assert property (p_enc_busy) else $error("enc short");
	property p_lock_ignore;
		auth_valid && auth_ready && auth_locked[auth_req.key_set] |=> auth_ready;
	endproperty
	a_lock_ignore: assert property (p_lock_ignore) else $error("locked set used");
	c_burn: cover property (fuse_burn);
	c_pass: cover property (take && auth_req.pass);
	c_refuse: cover property (s_axi_bvalid && s_axi_bresp == `SCAG_RESP_SLVERR);
endmodule : scag_top_monitor
bind scag_top scag_top_monitor scag_top_monitor_inst (.*);
`default_nettype wire

/* sim/scag_top_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "scag_consts.svh"
module scag_top_tb_top;
	import scag_pkg::*;
	localparam logic [1:0] rok = `SCAG_RESP_OKAY;
	localparam logic [1:0] rer = `SCAG_RESP_SLVERR;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] s_axi_awaddr = '0;
	logic [11:0] s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, go = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, fuse_burn_id;
	logic [31:0] s_axi_rdata, cip_word;
	logic [3:0] fuse_nv_in, auth_locked;
	logic fuse_burn, auth_valid, auth_ready;
	logic [7:0] zone_read_grant, zone_write_grant;
	scag_auth_t auth_req;
	scag_auth_t req = '0;
	scag_cip_sel_t cip_sel = '0;
	int mismatches = 0;
	int cmp_count = 0;
	int pc[16];
	int ac[4];
	int fz = 7;
	int s, k;
	int seq[6] = '{2, 1, 0, 2, 1, 2};
	bit eight, unl, ok;
	logic [31:0] rnd = 32'h7e28;
	logic [55:0] cm[4];
	logic [63:0] sm[4];
	scag_top scag_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fuse_nv_in, .fuse_burn, .fuse_burn_id,
		.auth_valid, .auth_req, .auth_ready, .auth_locked, .cip_sel, .cip_word,
		.zone_read_grant, .zone_write_grant);
	scag_engine_model scag_engine_model_inst (.aclk, .fuse_burn, .fuse_burn_id, .fuse_nv_in,
		.go, .req, .auth_ready, .auth_valid, .auth_req);
	initial forever #25 aclk = ~aclk;
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr
	function automatic int stp(input int v);
		return (v << 1) & (eight ? 255 : 238);
	endfunction : stp
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic rst();
		aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		eight = 0;
		unl = 0;
		foreach (pc[i]) pc[i] = 255;
		foreach (ac[i]) ac[i] = 255;
	endtask : rst
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		bit ta, tw;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end while ((s_axi_awvalid && !ta) || (s_axi_wvalid && !tw));
		do @(negedge aclk); while (!s_axi_bvalid);
		chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
		@(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(negedge aclk); while (!s_axi_arready);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		do @(negedge aclk); while (!s_axi_rvalid);
		chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
		if (er == rok) chk("rdata", s_axi_rdata, e);
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic pv(input int i);
		rnd = lfsr(rnd);
		wr(`SCAG_A_PWDAT, {8'h0, rnd[23:0]}, rok);
		wr(`SCAG_A_PWCMD, 32'(i), rok);
		if (pc[i] != 0) pc[i] = stp(pc[i]);
		rd(`SCAG_A_PCNT + 12'(4 * i), pc[i], rok);
	endtask : pv
	task automatic au(input int n, input bit p, input bit e);
		rnd = lfsr(rnd);
		@(posedge aclk);
		req <= {2'(n), e, p, rnd[23:0], ~rnd, rnd, rnd ^ 32'h5a5a};
		go <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
		do @(negedge aclk); while (!(auth_valid && auth_ready));
		@(posedge aclk);
		if (!p) ac[n] = stp(ac[n]);
		else if (ac[n] != 0 || unl)
		begin
			if (ac[n] != 0) ac[n] = 255;
			if (!e) cm[n] = req.crypt_new;
			sm[n] = req.skey_new;
		end
		rd(`SCAG_A_ACNT + 12'(4 * n), ac[n], rok);
	endtask : au
	task automatic ck(input int n);
		logic [127:0] w;
		w = {sm[n], 8'h00, cm[n]};
		for (int f = 0; f < 4; f++)
		begin
			cip_sel <= {2'(n), 2'(f >> 1), 1'(f)};
			repeat (2) @(posedge aclk);
			chk("cipher word", f == 1 ? {8'h0, cip_word[23:0]} : cip_word, w[32 * f +: 32]);
		end
	endtask : ck
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		rst();
		rd(`SCAG_A_FUSE, fz, rok);
		for (int i = 0; i < 16; i++) rd(`SCAG_A_PCNT + 12'(4 * i), 255, rok);
		for (int i = 0; i < 8; i++) rd(`SCAG_A_ZKEY + 12'(4 * i), 255, rok);
		for (int i = 0; i < 4; i++) rd(`SCAG_A_ACNT + 12'(4 * i), 255, rok);
		rd(12'h200, 0, rer);
		rd(`SCAG_A_BLOW, 0, rer);
		s_axi_wstrb <= 4'h3;
		wr(`SCAG_A_CTRL, 1, rer);
		s_axi_wstrb <= 4'hf;
		wr(`SCAG_A_ZKEY, 0, rer);
		$display("test refusals done");
		s = int'(rnd[2:0]);
		for (int j = 0; j < 5; j++) pv(2 * s + 1);
		chk("write grant", {24'h0, zone_write_grant}, 0);
		wr(`SCAG_A_CTRL, 1, rok);
		eight = 1;
		for (int j = 0; j < 9; j++) pv(2 * s);
		$display("test counters done");
		wr(`SCAG_A_CTRL, 0, rok);
		eight = 0;
		k = int'(rnd[4:3]);
		for (int j = 0; j < 4; j++) au(k, 0, 0);
		chk("locked", {28'h0, auth_locked}, 32'(1 << k));
		au(k, 1, 0);
		wr(`SCAG_A_CTRL, 2, rok);
		unl = 1;
		repeat (2) @(posedge aclk);
		chk("locked", {28'h0, auth_locked}, 0);
		au(k, 1, 0);
		ck(k);
		k = (k + 1) % 4;
		au(k, 0, 0);
		au(k, 1, 0);
		ck(k);
		au(k, 1, 1);
		ck(k);
		$display("test auth done");
		wr(`SCAG_A_MADR, `SCAG_W_TEST, rok);
		wr(`SCAG_A_MDAT, rnd, rok);
		rd(`SCAG_A_MDAT, rnd, rok);
		wr(`SCAG_A_MADR, `SCAG_W_LOT, rok);
		wr(`SCAG_A_MDAT, 0, rer);
		wr(`SCAG_A_MADR, 24, rok);
		rd(`SCAG_A_MDAT, 0, rer);
		foreach (seq[j])
		begin
			ok = seq[j] == 0 || (fz & (1 << (seq[j] - 1))) == 0;
			wr(`SCAG_A_BLOW, 32'(seq[j]), ok ? rok : rer);
			if (ok) fz = fz & ~(1 << seq[j]);
			rd(`SCAG_A_FUSE, fz, rok);
		end
		wr(`SCAG_A_MADR, `SCAG_W_MAKER, rok);
		wr(`SCAG_A_MDAT, 0, rer);
		rst();
		rd(`SCAG_A_FUSE, fz, rok);
		$display("test fuses done");
		give_verdict();
	end
	initial
	begin
		repeat (30000) @(posedge aclk);
		mismatches++;
		give_verdict();
	end
endmodule : scag_top_tb_top
`default_nettype wire
